// file: hw/tec_top.sv
// timer and external interrupt control register with event sources
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module tec_top (
   // clock and reset
   input  wire logic       CLOCK,
   input  wire logic       RESET_N,
   // register port
   input  wire logic [3:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // timer engine events
   input  wire logic       FIRST_TIMER_OVERFLOW,
   input  wire logic       SECOND_TIMER_OVERFLOW,
   input  wire logic       UPPER_BYTE_OVERFLOW,
   // vectoring acknowledges, one cycle
   input  wire logic       VEC_FIRST_TIMER,
   input  wire logic       VEC_SECOND_TIMER,
   input  wire logic       VEC_FIRST_EXT,
   input  wire logic       VEC_SECOND_EXT,
   // external inputs
   input  wire logic       FIRST_EXT_IRQ_INPUT,
   input  wire logic       SECOND_EXT_IRQ_INPUT,
   // counting enables to the timer engines
   output logic            FIRST_TIMER_COUNT_EN,
   output logic            SECOND_TIMER_COUNT_EN,
   output logic            UPPER_BYTE_COUNT_EN,
   // interrupt requests
   output logic            FIRST_TIMER_IRQ,
   output logic            SECOND_TIMER_IRQ,
   output logic            FIRST_EXT_IRQ,
   output logic            SECOND_EXT_IRQ,
   output logic            IRQ
);
   // ****************************************************************
   // storage
   // ****************************************************************
   logic [7:0] timer_and_ext_irq_control_q;
   logic [7:0] irq_stat_q;
   logic [7:0] irq_mask_q;
   logic [7:0] aux_q;
   logic [7:0] rdata_q;
   logic       wr_ctl;
   logic       wr_stat;
   logic       x0_active;
   logic       x1_active;
   logic       x0_set;
   logic       x1_set;
   logic       t0_set;
   logic       t1_set;
   logic [7:0] hw_set;
   logic [7:0] hw_clr;
   logic [7:0] events;

   assign wr_ctl  = WR && (ADDR == tec_pkg::ADDR_CONTROL);
   assign wr_stat = WR && (ADDR == tec_pkg::ADDR_IRQ_STAT);

   // ****************************************************************
   // external input detectors
   // ****************************************************************
   tec_ext_det u_det0 (
      .CLOCK     (CLOCK),
      .RESET_N   (RESET_N),
      .PIN       (FIRST_EXT_IRQ_INPUT),
      .POLARITY  (aux_q[tec_pkg::AUX_POL0]),
      .EDGE_MODE (timer_and_ext_irq_control_q[tec_pkg::BIT_X0_EDGE]),
      .ACTIVE    (x0_active),
      .SET_PULSE (x0_set)
   );

   tec_ext_det u_det1 (
      .CLOCK     (CLOCK),
      .RESET_N   (RESET_N),
      .PIN       (SECOND_EXT_IRQ_INPUT),
      .POLARITY  (aux_q[tec_pkg::AUX_POL1]),
      .EDGE_MODE (timer_and_ext_irq_control_q[tec_pkg::BIT_X1_EDGE]),
      .ACTIVE    (x1_active),
      .SET_PULSE (x1_set)
   );

   // ****************************************************************
   // hardware set and clear terms per control bit
   // ****************************************************************
   // in split mode the upper byte owns the second overflow flag
   assign t1_set = aux_q[tec_pkg::AUX_SPLIT] ? UPPER_BYTE_OVERFLOW
                                             : SECOND_TIMER_OVERFLOW;
   assign t0_set = FIRST_TIMER_OVERFLOW;

   // set and vector-clear vectors in control bit layout
   always_comb begin
      hw_set = 8'h00;
      hw_clr = 8'h00;
      hw_set[tec_pkg::BIT_T1_OVF]  = t1_set;
      hw_set[tec_pkg::BIT_T0_OVF]  = t0_set;
      hw_set[tec_pkg::BIT_X1_PEND] = x1_set;
      hw_set[tec_pkg::BIT_X0_PEND] = x0_set;
      hw_clr[tec_pkg::BIT_T1_OVF]  = VEC_SECOND_TIMER;
      hw_clr[tec_pkg::BIT_T0_OVF]  = VEC_FIRST_TIMER;
      // level mode sets the flag every cycle the pin is active, vector leaves it
      hw_clr[tec_pkg::BIT_X1_PEND] = VEC_SECOND_EXT &
         timer_and_ext_irq_control_q[tec_pkg::BIT_X1_EDGE];
      hw_clr[tec_pkg::BIT_X0_PEND] = VEC_FIRST_EXT &
         timer_and_ext_irq_control_q[tec_pkg::BIT_X0_EDGE];
   end

   // ****************************************************************
   // control register: one flop per bit, set beats every clear
   // ****************************************************************
   generate
      for (genvar i = 0; i < 8; i++) begin : g_bit
         always_ff @(posedge CLOCK) begin
            if (!RESET_N) begin
               timer_and_ext_irq_control_q[i] <= tec_pkg::RST_CONTROL[i];
            end else if (hw_set[i]) begin
               timer_and_ext_irq_control_q[i] <= 1'b1;
            end else if (wr_ctl) begin
               timer_and_ext_irq_control_q[i] <= WDATA[i];
            end else if (hw_clr[i]) begin
               timer_and_ext_irq_control_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // counting enables
   // ****************************************************************
   // enables only gate counting; the count itself is never touched here
   assign FIRST_TIMER_COUNT_EN =
      timer_and_ext_irq_control_q[tec_pkg::BIT_T0_RUN] &
      (~aux_q[tec_pkg::AUX_FIRST_TIMER_GATE_CONTROL] | x0_active);
   assign SECOND_TIMER_COUNT_EN =
      timer_and_ext_irq_control_q[tec_pkg::BIT_T1_RUN] &
      (~aux_q[tec_pkg::AUX_GATE1] | x1_active);
   assign UPPER_BYTE_COUNT_EN = aux_q[tec_pkg::AUX_SPLIT] &
      timer_and_ext_irq_control_q[tec_pkg::BIT_T1_RUN];

   // ****************************************************************
   // interrupt requests to the vectoring logic
   // ****************************************************************
   assign FIRST_TIMER_IRQ  = timer_and_ext_irq_control_q[tec_pkg::BIT_T0_OVF];
   assign SECOND_TIMER_IRQ = timer_and_ext_irq_control_q[tec_pkg::BIT_T1_OVF];
   assign FIRST_EXT_IRQ    = timer_and_ext_irq_control_q[tec_pkg::BIT_X0_PEND];
   assign SECOND_EXT_IRQ   = timer_and_ext_irq_control_q[tec_pkg::BIT_X1_PEND];

   // ****************************************************************
   // sticky event status, mask and summary interrupt
   // ****************************************************************
   // status uses control bit layout; only flag positions ever set
   assign events = hw_set;

   // write one clears, but a same-cycle event keeps the bit
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         irq_stat_q <= tec_pkg::RST_IRQ;
      end else begin
         irq_stat_q <= events |
            (irq_stat_q & ~(wr_stat ? WDATA : 8'h00));
      end
   end

   // mask register
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         irq_mask_q <= tec_pkg::RST_IRQ;
      end else if (WR && (ADDR == tec_pkg::ADDR_IRQ_MASK)) begin
         irq_mask_q <= WDATA;
      end
   end

   assign IRQ = |(irq_stat_q & irq_mask_q);

   // auxiliary configuration: polarity, gate and split mode
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         aux_q <= tec_pkg::RST_AUX;
      end else if (WR && (ADDR == tec_pkg::ADDR_AUX_CFG)) begin
         aux_q <= WDATA & tec_pkg::AUX_MASK;
      end
   end

   // ****************************************************************
   // read port: data one cycle after the strobe, zero elsewhere
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         rdata_q <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            tec_pkg::ADDR_CONTROL:  rdata_q <= timer_and_ext_irq_control_q;
            tec_pkg::ADDR_IRQ_STAT: rdata_q <= irq_stat_q;
            tec_pkg::ADDR_IRQ_MASK: rdata_q <= irq_mask_q;
            tec_pkg::ADDR_AUX_CFG:  rdata_q <= aux_q;
            default:                rdata_q <= 8'h00; // unmapped reads zero
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign RDATA = rdata_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   second_ovf_set_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      t1_set |=> timer_and_ext_irq_control_q[tec_pkg::BIT_T1_OVF])
      else $error("second overflow flag not set");

   first_ovf_vec_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (VEC_FIRST_TIMER && !t0_set && !wr_ctl)
      |=> !timer_and_ext_irq_control_q[tec_pkg::BIT_T0_OVF])
      else $error("first overflow flag not cleared by vector");

   second_run_en_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      !timer_and_ext_irq_control_q[tec_pkg::BIT_T1_RUN]
      |-> !SECOND_TIMER_COUNT_EN)
      else $error("second timer counts while stopped");

   first_run_en_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (timer_and_ext_irq_control_q[tec_pkg::BIT_T0_RUN] &&
       !aux_q[tec_pkg::AUX_FIRST_TIMER_GATE_CONTROL]) |-> FIRST_TIMER_COUNT_EN)
      else $error("first timer not counting while run");

   level_keep_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (!timer_and_ext_irq_control_q[tec_pkg::BIT_X1_EDGE] &&
       timer_and_ext_irq_control_q[tec_pkg::BIT_X1_PEND] &&
       VEC_SECOND_EXT && !wr_ctl)
      |=> timer_and_ext_irq_control_q[tec_pkg::BIT_X1_PEND])
      else $error("level pending cleared by vector");

   edge_once_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (timer_and_ext_irq_control_q[tec_pkg::BIT_X0_EDGE] &&
       $past(x0_active) && x0_active) |-> !x0_set)
      else $error("edge mode sets without an edge");

   gate_block_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (aux_q[tec_pkg::AUX_GATE1] && !x1_active)
      |-> !SECOND_TIMER_COUNT_EN)
      else $error("gated timer counts while input inactive");

   split_flag_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (aux_q[tec_pkg::AUX_SPLIT] && UPPER_BYTE_OVERFLOW)
      |=> timer_and_ext_irq_control_q[tec_pkg::BIT_T1_OVF])
      else $error("upper byte overflow lost");

   set_wins_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (t0_set && wr_stat) |=> irq_stat_q[tec_pkg::BIT_T0_OVF])
      else $error("status event lost to clear");

   level_repend_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      (!timer_and_ext_irq_control_q[tec_pkg::BIT_X0_EDGE] && x0_active)
      |=> timer_and_ext_irq_control_q[tec_pkg::BIT_X0_PEND])
      else $error("level input did not pend");

   run_write_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      wr_ctl |=> (timer_and_ext_irq_control_q[tec_pkg::BIT_T0_RUN] ==
                  $past(WDATA[tec_pkg::BIT_T0_RUN])))
      else $error("run bit write did not land");

   cov_ovf_c: cover property (@(posedge CLOCK) disable iff (!RESET_N)
      t0_set ##1 IRQ);
   cov_edge_c: cover property (@(posedge CLOCK) disable iff (!RESET_N)
      x1_set ##[1:4] VEC_SECOND_EXT);
   cov_split_c: cover property (@(posedge CLOCK) disable iff (!RESET_N)
      aux_q[tec_pkg::AUX_SPLIT] && UPPER_BYTE_OVERFLOW);
endmodule

// file: hw/tec_pkg.sv
// constants for the timer and external interrupt control register
//
// How it works
// - second timer overflow (upper byte overflow in split mode) sets bit 7, vectoring clears
// - first timer overflow sets bit 5, vectoring clears
// - bit 6 runs or stops second timer
// - bit 4 runs or stops first timer
// - bit 3 pends second input; vector clears edge
// - bit 1 pends first input; vector clears edge
// - bit 2: second input level 0, edge 1
// - bit 0: first input level 0, edge 1
// - polarity bit applied before edge/level detection
// - count when run and (no gate or active)
// - split mode: upper byte uses second run bit
// - run bit never clears or reloads count
package tec_pkg;
   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [3:0] ADDR_CONTROL  = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
   localparam logic [3:0] ADDR_AUX_CFG  = 4'h3;
   // ****************************************************************
   // control field positions
   // ****************************************************************
   localparam int BIT_T1_OVF  = 7;
   localparam int BIT_T1_RUN  = 6;
   localparam int BIT_T0_OVF  = 5;
   localparam int BIT_T0_RUN  = 4;
   localparam int BIT_X1_PEND = 3;
   localparam int BIT_X1_EDGE = 2;
   localparam int BIT_X0_PEND = 1;
   localparam int BIT_X0_EDGE = 0;
   // ****************************************************************
   // auxiliary config: polarity, gate, split mode
   // ****************************************************************
   localparam int AUX_POL0  = 0;
   localparam int AUX_POL1  = 1;
   localparam int AUX_FIRST_TIMER_GATE_CONTROL = 2;
   localparam int AUX_GATE1 = 3;
   localparam int AUX_SPLIT = 4;
   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_IRQ     = 8'h00;
   localparam logic [7:0] RST_AUX     = 8'h00;
   localparam logic [7:0] AUX_MASK    = 8'h1F;
endpackage

// file: hw/tec_ext_det.sv
// one external interrupt input detector: polarity then edge or level
`timescale 1ns/1ps
module tec_ext_det (
   // clock and reset
   input  wire logic CLOCK,
   input  wire logic RESET_N,
   // pin and configuration
   input  wire logic PIN,
   input  wire logic POLARITY,
   input  wire logic EDGE_MODE,
   // results
   output logic      ACTIVE,
   output logic      SET_PULSE
);
   logic prev_q;

   // polarity applied first so both detectors see the active sense
   assign ACTIVE = (PIN == POLARITY);

   // previous active level for edge detection
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= ACTIVE;
      end
   end

   // level mode sets every cycle while active; edge only on onset
   assign SET_PULSE = EDGE_MODE ? (ACTIVE & ~prev_q) : ACTIVE;
endmodule

// file: bench/tec_cpu_model.sv
// cpu core model: vectors to the lowest pending request after a lag
`timescale 1ns/1ps
module tec_cpu_model (
   // clock and reset
   input  wire logic       CLOCK,
   input  wire logic       RESET_N,
   // requests from the block
   input  wire logic       FIRST_TIMER_IRQ,
   input  wire logic       SECOND_TIMER_IRQ,
   input  wire logic       FIRST_EXT_IRQ,
   input  wire logic       SECOND_EXT_IRQ,
   // behaviour set by the bench
   input  wire logic       AUTO_EN,
   input  wire logic [3:0] LAG,
   // vectoring acknowledges, one cycle each
   output logic            VEC_FIRST_TIMER,
   output logic            VEC_SECOND_TIMER,
   output logic            VEC_FIRST_EXT,
   output logic            VEC_SECOND_EXT
);
   logic [4:0] wait_q = 5'h00;
   logic [3:0] vec_q  = 4'h0;
   logic [3:0] req;
   assign req = {SECOND_EXT_IRQ, FIRST_EXT_IRQ, SECOND_TIMER_IRQ,
                 FIRST_TIMER_IRQ};
   assign {VEC_SECOND_EXT, VEC_FIRST_EXT, VEC_SECOND_TIMER,
           VEC_FIRST_TIMER} = vec_q;
   // waiting past the lag by one lets a cleared flag show before re-vectoring
   always_ff @(posedge CLOCK) begin
      vec_q <= 4'h0;
      if (!RESET_N || !AUTO_EN || req == 4'h0) begin
         wait_q <= 5'h00;
      end else if (wait_q <= {1'b0, LAG}) begin
         wait_q <= wait_q + 5'h01;
      end else begin
         wait_q <= 5'h00;
         vec_q  <= req & (~req + 4'h1);
      end
   end
endmodule

// file: bench/tb_top.sv
// self-checking bench for the timer and external interrupt control block
`timescale 1ns/1ps
module tb_top;
   // ****************************************************************
   // signals and reference state
   // ****************************************************************
   logic        clock = 0, reset_n = 0, wr = 0, rd = 0, chk_on = 1;
   logic [3:0]  addr = 4'h0, lag = 4'h0;
   logic [7:0]  wdata = 8'h00, rdata, m_ctl, m_sts, m_msk, m_aux, m_rd;
   logic        o0 = 0, o1 = 0, ou = 0, p0 = 1, p1 = 1, auto = 0;
   logic        vt0, vt1, vx0, vx1, e0, e1, eu, it0, it1, ix0, ix1, irq;
   logic        q0, q1;
   logic [31:0] rng = 32'h39;
   int          miscompares = 0, checks_done = 0, cyc = 0;
   always #5 clock = ~clock;
   tec_top i_tec_top (.CLOCK(clock), .RESET_N(reset_n), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .FIRST_TIMER_OVERFLOW(o0), .SECOND_TIMER_OVERFLOW(o1),
      .UPPER_BYTE_OVERFLOW(ou), .VEC_FIRST_TIMER(vt0),
      .VEC_SECOND_TIMER(vt1), .VEC_FIRST_EXT(vx0), .VEC_SECOND_EXT(vx1),
      .FIRST_EXT_IRQ_INPUT(p0), .SECOND_EXT_IRQ_INPUT(p1),
      .FIRST_TIMER_COUNT_EN(e0), .SECOND_TIMER_COUNT_EN(e1),
      .UPPER_BYTE_COUNT_EN(eu), .FIRST_TIMER_IRQ(it0),
      .SECOND_TIMER_IRQ(it1), .FIRST_EXT_IRQ(ix0), .SECOND_EXT_IRQ(ix1),
      .IRQ(irq));
   tec_cpu_model i_tec_cpu_model (.CLOCK(clock), .RESET_N(reset_n),
      .FIRST_TIMER_IRQ(it0), .SECOND_TIMER_IRQ(it1), .FIRST_EXT_IRQ(ix0),
      .SECOND_EXT_IRQ(ix1), .AUTO_EN(auto), .LAG(lag),
      .VEC_FIRST_TIMER(vt0), .VEC_SECOND_TIMER(vt1),
      .VEC_FIRST_EXT(vx0), .VEC_SECOND_EXT(vx1));
   // ****************************************************************
   // reference model, sampled on the same edge as the design
   // ****************************************************************
   always @(posedge clock) begin : model
      logic       a0, a1, s0, s1;
      logic [7:0] ev, c;
      if (!reset_n) begin
         {m_ctl, m_sts, m_msk, m_aux, m_rd, q0, q1} = 42'h0;
      end else begin
         a0 = (p0 === m_aux[0]);
         a1 = (p1 === m_aux[1]);
         s0 = m_ctl[0] ? a0 & !q0 : a0;
         s1 = m_ctl[2] ? a1 & !q1 : a1;
         {q0, q1} = {a0, a1};
         ev = {m_aux[4] ? ou : o1, 1'b0, o0, 1'b0, s1, 1'b0, s0, 1'b0};
         m_rd = !rd ? 8'h00 : addr == 4'h0 ? m_ctl : addr == 4'h1 ? m_sts
              : addr == 4'h2 ? m_msk : addr == 4'h3 ? m_aux : 8'h00;
         c = m_ctl & ~{vt1, 1'b0, vt0, 1'b0, vx1 & m_ctl[2], 1'b0,
                       vx0 & m_ctl[0], 1'b0};
         if (wr && addr == 4'h0) c = wdata;
         m_ctl = c | ev;
         if (wr && addr == 4'h1) m_sts = m_sts & ~wdata;
         m_sts = m_sts | ev;
         if (wr && addr == 4'h2) m_msk = wdata;
         if (wr && addr == 4'h3) m_aux = wdata & 8'h1F;
      end
   end
   // ****************************************************************
   // comparison, bus and report tasks
   // ****************************************************************
   task automatic cmp(input string what, input logic [7:0] e, g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clock);
      {addr, rd} <= {a, 1'b1};
      @(posedge clock);
      rd <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // outputs are looked at mid-cycle, once every update has landed
   always @(negedge clock) begin
      if (reset_n) begin
         cmp("read data", m_rd, rdata);
         if (chk_on) begin
            cmp("flags", {m_ctl[7], m_ctl[5], m_ctl[3], m_ctl[1]},
                {it1, it0, ix1, ix0});
            cmp("irq", |(m_sts & m_msk), irq);
            cmp("count enables", {m_aux[4] & m_ctl[6], m_ctl[6] &
                (!m_aux[3] | (p1 === m_aux[1])), m_ctl[4] &
                (!m_aux[2] | (p0 === m_aux[0]))},
                {eu, e1, e0});
         end
      end
   end
   // a hang counts as a failure
   always @(posedge clock) begin
      cyc++;
      if (cyc == 4000) begin
         miscompares++;
         final_report;
      end
   end
   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      tick(20);
      reset_n <= 1'b1;
      for (int a = 0; a < 5; a++) rd_reg(a == 4 ? 4'h9 : a[3:0]);
      wr_reg(4'h9, 8'hFF);
      rd_reg(4'h9);
      wr_reg(4'h3, 8'hFF);
      wr_reg(4'h2, 8'hAA);
      wr_reg(4'h0, 8'hFA);
      for (int a = 0; a < 4; a++) rd_reg(a[3:0]);
      wr_reg(4'h3, 8'h00);
      $display("test registers done");
      // software clear and overflow in one cycle: the overflow wins
      @(posedge clock);
      {addr, wdata, wr, o0} <= {4'h0, 8'h00, 1'b1, 1'b1};
      @(posedge clock);
      {addr, wdata, wr, o0, o1} <= {4'h1, 8'hFF, 1'b1, 1'b0, 1'b1};
      @(posedge clock);
      {wr, o1} <= 2'h0;
      rd_reg(4'h0);
      rd_reg(4'h1);
      {lag, auto} <= {4'h2, 1'b1};
      tick(14);
      auto <= 1'b0;
      rd_reg(4'h0);
      wr_reg(4'h1, 8'hFF);
      $display("test overflow and vectoring done");
      for (int i = 0; i < 64; i++) begin
         wr_reg(4'h3, {4'h0, i[3:0]});
         wr_reg(4'h0, {1'b0, i[4], 1'b0, i[5], 4'h0});
         {p0, p1} <= i[1:0] ^ i[5:4];
         tick(2);
      end
      wr_reg(4'h3, 8'h10);
      wr_reg(4'h0, 8'h40);
      {o1, ou} <= 2'h2;
      @(posedge clock);
      {o1, ou} <= 2'h1;
      @(posedge clock);
      ou <= 1'b0;
      rd_reg(4'h0);
      wr_reg(4'h3, 8'h00);
      $display("test run, gate and split done");
      // level inputs re-pend after a clear; the first input, the only one vectored here, survives vectoring
      {p0, p1, auto} <= 3'h1;
      wr_reg(4'h0, 8'h00);
      tick(12);
      {p0, p1, auto} <= 3'h6;
      wr_reg(4'h0, 8'h00);
      // edge mode: flags are followed every cycle as well as by reads
      wr_reg(4'h0, 8'h05);
      {p0, p1} <= 2'h0;
      @(posedge clock);
      {p0, p1} <= 2'h3;
      tick(3);
      rd_reg(4'h0);
      {p0, p1} <= 2'h0;
      tick(3);
      wr_reg(4'h0, 8'h05);
      tick(3);
      rd_reg(4'h0);
      {p0, p1} <= 2'h3;
      tick(2);
      {p0, p1, auto} <= 3'h1;
      tick(14);
      {p0, p1, auto} <= 3'h6;
      tick(3);
      rd_reg(4'h0);
      wr_reg(4'h0, 8'h00);
      chk_on <= 1'b1;
      $display("test external inputs done");
      for (int n = 0; n < 400; n++) begin
         @(posedge clock);
         rng = xs(rng);
         {o0, o1, ou} <= {rng[2:0] == 3'h0, rng[5:3] == 3'h0, rng[7:6] == 0};
         wr <= rng[11:9] == 3'h0;
         rd <= rng[11:9] != 3'h0 && rng[25];
         addr <= {2'h0, rng[13:12]};
         wdata <= rng[23:16] & (rng[13:12] == 2'h2 ? 8'hAA : 8'hFA);
         {p0, p1, auto, lag} <= {rng[28:26], 1'b0, rng[31:29]};
      end
      @(posedge clock);
      {wr, rd, o0, o1, ou, auto} <= 6'h00;
      tick(3);
      $display("test random traffic done");
      final_report;
   end
endmodule
